// ===== common/timer_pkg.sv
// shared constants and types of the two-channel capture/compare timer
package timer_pkg;

  // ************************************************************
  // register map (byte registers on an 8-bit port)
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam logic [3:0] A_TIMER_CTRL = 4'h0;
  localparam logic [3:0] A_COUNT_HI = 4'h1;
  localparam logic [3:0] A_COUNT_LO = 4'h2;
  localparam logic [3:0] A_WRAP_HI = 4'h3;
  localparam logic [3:0] A_WRAP_LO = 4'h4;
  localparam logic [3:0] A_CHAN_BASE = 4'h5;
  localparam logic [3:0] CHAN_STRIDE = 4'h3;
  localparam logic [3:0] CHAN_CTRL_OFS = 4'h0;
  localparam logic [3:0] CHAN_HI_OFS = 4'h1;
  localparam logic [3:0] CHAN_LO_OFS = 4'h2;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int B_OVF_FLAG = 7;
  localparam int B_OVF_IE = 6;
  localparam int B_HALT = 5;
  localparam int B_CLEAR = 4;
  localparam int B_CF = 7;
  localparam int B_CIE = 6;
  localparam int B_BUF = 5;
  localparam int B_UNBUF = 4;
  localparam int B_ELH = 3;
  localparam int B_ELL = 2;
  localparam int B_TOV = 1;
  localparam int B_FMAX = 0;

  // ************************************************************
  // reset values and encodings
  // ************************************************************
  localparam logic [15:0] WRAP_RST = 16'hFFFF;
  localparam logic HALT_RST = 1'b1;
  localparam logic [2:0] PS_RST = 3'h0;
  localparam logic [2:0] PS_OFF = 3'h7;
  localparam int PS_DIV_W = 6;
  localparam logic [1:0] EL_NONE = 2'h0;
  localparam logic [1:0] EL_TOGGLE = 2'h1;
  localparam logic [1:0] EL_LOW = 2'h2;
  localparam logic [1:0] EL_HIGH = 2'h3;

  typedef enum {CH_PORT, CH_CAPTURE, CH_COMPARE, CH_OFF} chan_mode_e;

endpackage

// ===== rtl/capture_compare_timer_regs.sv
// two-channel 16-bit capture/compare timer with its byte register file
//
// Overview of operation
// - each channel is capture or compare on its own; only channel 0 buffers
// - overflow flag sets when the counter reaches the wrap value; reset clears
// - overflow flag clears by read with flag set, then write 0; new event wins
// - overflow interrupt request follows the flag when its enable is 1
// - halt holds the counter; reset sets halt
// - writing the clear bit zeroes counter and prescaler; it always reads 0
// - halt and clear in one write leave the counter stopped at zero
// - prescale codes 0 to 6 divide by 1 to 64; code 7 unavailable
// - counter is read-only; reading high byte latches low byte until read
// - at the wrap value the flag sets and counting restarts at zero next tick
// - writing wrap high byte blocks overflow flag until wrap low written
// - reset sets every bit of the wrap value
// - channel flag sets on active pin edge in capture, on match in compare
// - channel flag clears by read with flag set, then write 0, or by write 0 alone with its enable 0; event wins
// - channel interrupt enable gates the channel flag onto its request
// - channel 0 buffered select disables channel 1 and frees its pin
// - with edge field zero the pin is port owned and select sets preset level
// - capture edges: 01 rising, 10 falling, 11 both
// - compare action: 01 toggle, 10 low, 11 high, 00 flag only
// - toggle on overflow in compare mode; overflow beats a coincident match
// - full duty force with overflow toggle gives 100% from next period
// - value high read blocks capture, value high write blocks compare
// - buffered mode starts on channel 0 values, then last written at overflow
`timescale 1ns/1ns
`default_nettype none
module capture_compare_timer_regs
  import timer_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [timer_pkg::ADDR_W-1:0] addr,
  input wire logic [timer_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [timer_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] chan_pin_in,
  output logic [1:0] chan_pin_out,
  output logic [1:0] chan_pin_oe,
  output logic ovf_irq,
  output logic [1:0] chan_irq
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] lo_buf;
    logic lo_latched;
    logic [15:0] wrap;
    logic wrap_hold;
    logic ovf_flag;
    logic ovf_arm;
    logic ovf_ie;
    logic halt;
    logic [2:0] ps;
    logic [1:0] cf;
    logic [1:0] carm;
    logic [1:0] cie;
    logic [1:0] unbuf;
    logic [1:0][1:0] el;
    logic [1:0] tov;
    logic [1:0] fmax;
    logic [1:0] max_eff;
    logic [1:0] hold;
    logic [1:0][15:0] val;
    logic [1:0] prev;
    logic bufsel;
    logic buf_cur;
    logic buf_last;
    logic [7:0] rdata;
    logic ovf_irq;
    logic [1:0] chan_irq;
    logic [1:0] pin;
    logic [1:0] oe;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  logic [1:0] pin_sync_q;
  logic tick;
  logic clr_wr;
  logic [15:0] inc;
  logic ovf_ev;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] cap_ev;
  logic [1:0] cmp_ev;
  logic [1:0] disabled;
  chan_mode_e mode [2];
  logic [15:0] cmp_val [2];
  logic cmp_hold [2];

  // ************************************************************
  // helpers
  // ************************************************************

  // address of register k of channel i
  function automatic logic [3:0] chan_reg(input int i, input logic [3:0] k);
    logic [3:0] base;
    base = A_CHAN_BASE + (i[0] ? CHAN_STRIDE : 4'h0);
    return base + k;
  endfunction

  // operating mode of a channel from its control bits
  function automatic chan_mode_e chan_mode(input logic off, input logic bsel,
                                           input logic ub, input logic [1:0] e);
    if (off) begin
      return CH_OFF;
    end else if (bsel || ub) begin
      return CH_COMPARE;
    end else if (e != EL_NONE) begin
      return CH_CAPTURE;
    end else begin
      return CH_PORT;
    end
  endfunction

  // ************************************************************
  // submodules
  // ************************************************************
  pin_sync #(.W(2)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(chan_pin_in),
    .sync_out(pin_sync_q)
  );

  prescaler u_presc (
    .clock(clock),
    .reset_n(reset_n),
    .clear(clr_wr),
    .run(!s_r.halt),
    .select(s_r.ps),
    .tick(tick)
  );

  // ************************************************************
  // next-state logic
  // ************************************************************

  // counter, overflow, channel events and register accesses
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    clr_wr = wr && (addr == A_TIMER_CTRL) && wdata[B_CLEAR];
    inc = (s_r.cnt == s_r.wrap) ? 16'h0000 : s_r.cnt + 16'h0001;
    ovf_ev = tick && (inc == s_r.wrap) && !s_r.wrap_hold;

    // counter advance or clear; a clear beside halt leaves zero
    if (clr_wr) begin
      s_nxt.cnt = 16'h0000;
    end else if (tick) begin
      s_nxt.cnt = inc;
    end

    // timer control register
    if (rd && addr == A_TIMER_CTRL) begin
      s_nxt.rdata = {s_r.ovf_flag, s_r.ovf_ie, s_r.halt, 2'b00, s_r.ps};
      if (s_r.ovf_flag) begin
        s_nxt.ovf_arm = 1'b1;
      end
    end
    if (wr && addr == A_TIMER_CTRL) begin
      s_nxt.ovf_ie = wdata[B_OVF_IE];
      s_nxt.halt = wdata[B_HALT];
      s_nxt.ps = wdata[2:0];
      if (!wdata[B_OVF_FLAG] && s_r.ovf_arm) begin
        s_nxt.ovf_flag = 1'b0;
      end
      s_nxt.ovf_arm = 1'b0;
    end
    // a new overflow beats a pending clear
    if (ovf_ev) begin
      s_nxt.ovf_flag = 1'b1;
      s_nxt.ovf_arm = 1'b0;
    end

    // counter bytes with low-byte latch
    if (rd && addr == A_COUNT_HI) begin
      s_nxt.rdata = s_r.cnt[15:8];
      if (!s_r.lo_latched) begin
        s_nxt.lo_buf = s_r.cnt[7:0];
        s_nxt.lo_latched = 1'b1;
      end
    end
    if (rd && addr == A_COUNT_LO) begin
      s_nxt.rdata = s_r.lo_latched ? s_r.lo_buf : s_r.cnt[7:0];
      s_nxt.lo_latched = 1'b0;
    end

    // wrap value bytes
    if (rd && addr == A_WRAP_HI) begin
      s_nxt.rdata = s_r.wrap[15:8];
    end
    if (rd && addr == A_WRAP_LO) begin
      s_nxt.rdata = s_r.wrap[7:0];
    end
    if (wr && addr == A_WRAP_HI) begin
      s_nxt.wrap[15:8] = wdata;
      s_nxt.wrap_hold = 1'b1;
    end
    if (wr && addr == A_WRAP_LO) begin
      s_nxt.wrap[7:0] = wdata;
      s_nxt.wrap_hold = 1'b0;
    end

    // buffered pair: source switches to the last written at overflow
    if (ovf_ev && s_r.bufsel) begin
      s_nxt.buf_cur = s_r.buf_last;
    end

    for (int i = 0; i < 2; i++) begin
      disabled[i] = (i == 1) && s_r.bufsel;
      mode[i] = chan_mode(disabled[i], (i == 0) && s_r.bufsel,
                          s_r.unbuf[i], s_r.el[i]);
      if (i == 0 && s_r.bufsel) begin
        cmp_val[i] = s_r.val[s_r.buf_cur];
        cmp_hold[i] = s_r.hold[s_r.buf_cur];
      end else begin
        cmp_val[i] = s_r.val[i];
        cmp_hold[i] = s_r.hold[i];
      end

      // edge detect on the synchronised pin
      rise[i] = pin_sync_q[i] && !s_r.prev[i];
      fall[i] = !pin_sync_q[i] && s_r.prev[i];
      s_nxt.prev[i] = pin_sync_q[i];
      cap_ev[i] = (mode[i] == CH_CAPTURE) && !s_r.hold[i] &&
                  ((s_r.el[i][0] && rise[i]) || (s_r.el[i][1] && fall[i]));
      cmp_ev[i] = (mode[i] == CH_COMPARE) && !cmp_hold[i] && tick &&
                  (inc == cmp_val[i]);

      // capture stores the counter
      if (cap_ev[i]) begin
        s_nxt.val[i] = s_r.cnt;
      end

      // pin level: preset, overflow toggle or compare action
      if (s_r.el[i] == EL_NONE) begin
        s_nxt.pin[i] = !s_r.unbuf[i];
      end else if (mode[i] == CH_COMPARE) begin
        if (ovf_ev && s_r.tov[i]) begin
          s_nxt.max_eff[i] = s_r.fmax[i];
          s_nxt.pin[i] = s_r.fmax[i] ? !s_r.el[i][0] : !s_r.pin[i];
        end else if (cmp_ev[i] && !(s_r.max_eff[i] && s_r.tov[i])) begin
          case (s_r.el[i])
            EL_TOGGLE: s_nxt.pin[i] = !s_r.pin[i];
            EL_LOW: s_nxt.pin[i] = 1'b0;
            EL_HIGH: s_nxt.pin[i] = 1'b1;
            default: s_nxt.pin[i] = s_r.pin[i];
          endcase
        end
      end
      s_nxt.oe[i] = (mode[i] == CH_COMPARE) && (s_r.el[i] != EL_NONE);

      // channel control register
      if (rd && addr == chan_reg(i, CHAN_CTRL_OFS)) begin
        s_nxt.rdata = {s_r.cf[i], s_r.cie[i], (i == 0) && s_r.bufsel,
                       s_r.unbuf[i], s_r.el[i], s_r.tov[i], s_r.fmax[i]};
        if (s_r.cf[i]) begin
          s_nxt.carm[i] = 1'b1;
        end
      end
      if (wr && addr == chan_reg(i, CHAN_CTRL_OFS) && !disabled[i]) begin
        s_nxt.cie[i] = wdata[B_CIE];
        s_nxt.unbuf[i] = wdata[B_UNBUF];
        s_nxt.el[i] = {wdata[B_ELH], wdata[B_ELL]};
        s_nxt.tov[i] = wdata[B_TOV];
        s_nxt.fmax[i] = wdata[B_FMAX];
        if (i == 0) begin
          s_nxt.bufsel = wdata[B_BUF];
          if (wdata[B_BUF] && !s_r.bufsel) begin
            s_nxt.buf_cur = 1'b0;
            s_nxt.buf_last = 1'b0;
          end
        end
        if (!wdata[B_CF] && (s_r.carm[i] || !s_r.cie[i])) begin
          s_nxt.cf[i] = 1'b0;
        end
        s_nxt.carm[i] = 1'b0;
      end
      // a new event beats a pending clear
      if (cap_ev[i] || cmp_ev[i]) begin
        s_nxt.cf[i] = 1'b1;
        s_nxt.carm[i] = 1'b0;
      end

      // channel value bytes
      if (rd && addr == chan_reg(i, CHAN_HI_OFS)) begin
        s_nxt.rdata = s_r.val[i][15:8];
        if (mode[i] == CH_CAPTURE) begin
          s_nxt.hold[i] = 1'b1;
        end
      end
      if (rd && addr == chan_reg(i, CHAN_LO_OFS)) begin
        s_nxt.rdata = s_r.val[i][7:0];
        if (mode[i] == CH_CAPTURE) begin
          s_nxt.hold[i] = 1'b0;
        end
      end
      if (wr && addr == chan_reg(i, CHAN_HI_OFS)) begin
        s_nxt.val[i][15:8] = wdata;
        s_nxt.buf_last = i[0];
        if (mode[i] != CH_CAPTURE) begin
          s_nxt.hold[i] = 1'b1;
        end
      end
      if (wr && addr == chan_reg(i, CHAN_LO_OFS)) begin
        s_nxt.val[i][7:0] = wdata;
        s_nxt.buf_last = i[0];
        s_nxt.hold[i] = 1'b0;
      end

      // interrupt request follows the flag under its enable
      s_nxt.chan_irq[i] = s_nxt.cf[i] && s_nxt.cie[i] && !disabled[i];
    end

    s_nxt.ovf_irq = s_nxt.ovf_flag && s_nxt.ovf_ie;
  end

  // ************************************************************
  // state register
  // ************************************************************

  // synchronous reset to documented values
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.halt <= HALT_RST;
      s_r.ps <= PS_RST;
      s_r.wrap <= WRAP_RST;
      s_r.pin <= 2'b11;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************

  // every output is a state flip-flop
  assign rdata = s_r.rdata;
  assign chan_pin_out = s_r.pin;
  assign chan_pin_oe = s_r.oe;
  assign ovf_irq = s_r.ovf_irq;
  assign chan_irq = s_r.chan_irq;

endmodule
`default_nettype wire

// ===== rtl/pin_sync.sv
// two-flop synchroniser for the channel pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 2
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/prescaler.sv
// counter prescaler: one-cycle tick at the bus clock divided by 2**select for select 0 to 6, no tick for select 7
`timescale 1ns/1ns
`default_nettype none
module prescaler
  import timer_pkg::*;
#(
  parameter int DIV_W = timer_pkg::PS_DIV_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic run,
  input wire logic [2:0] select,
  output logic tick
);
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic [DIV_W-1:0] mask;

  // tick when the low select bits of the divider are all ones
  always_comb begin
    mask = ~({DIV_W{1'b1}} << select);
    tick = run && (select != PS_OFF) && ((div_r & mask) == mask);
    div_nxt = div_r;
    if (clear) begin
      div_nxt = '0;
    end else if (run) begin
      div_nxt = div_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== verification/capture_compare_timer_regs_tb_top.sv
// self-checking bench for the two-channel capture/compare timer
`timescale 1ns/1ns
`default_nettype none
module capture_compare_timer_regs_tb_top;
  import timer_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, v, v2;
  logic [1:0] pin_in, pin_out, pin_oe, chan_irq;
  logic [1:0] drive_lvl = 2'h0;
  logic ovf_irq, p1, p2;
  logic [15:0] ex;
  logic [3:0] n;
  int mismatches = 0;
  int comparisons = 0;
  // address and expected reset read value
  logic [11:0] rows [12] = '{12'h020, 12'h100, 12'h200, 12'h3FF, 12'h4FF, 12'h500,
    12'h600, 12'h700, 12'h800, 12'h900, 12'hA00, 12'hB00};
  always #5 clock = ~clock;
  capture_compare_timer_regs dut (.clock(clock), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .chan_pin_in(pin_in),
    .chan_pin_out(pin_out), .chan_pin_oe(pin_oe), .ovf_irq(ovf_irq), .chan_irq(chan_irq));
  pin_partner far (.drive_lvl(drive_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_lvl(pin_in));
  // compare, bus cycles and waiting
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic r(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // high cycles of the channel 0 pin over one six-cycle period
  task automatic highs(output logic [3:0] k);
    k = 4'h0;
    repeat (6) begin
      idle(1);
      k = k + {3'h0, pin_out[0]};
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    idle(20000);
    mismatches++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    idle(4);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      r(rows[i][11:8], v);
      chk(v, rows[i][7:0]);
    end
    for (int ps = 0; ps < 8; ps++) begin
      w(A_TIMER_CTRL, 8'h30 | ps[7:0]);
      w(A_TIMER_CTRL, ps[7:0]);
      idle(126);
      w(A_TIMER_CTRL, 8'h20 | ps[7:0]);
      r(A_COUNT_HI, v);
      r(A_COUNT_LO, v2);
      ex = (ps == 7) ? 16'h0000 : 16'd128 >> ps;
      chk({v, v2}, ex);
    end
    r(A_COUNT_HI, v);
    w(A_TIMER_CTRL, 8'h00);
    idle(40);
    w(A_TIMER_CTRL, 8'h20);
    r(A_COUNT_HI, v);
    r(A_COUNT_LO, v2);
    chk(v2, 8'h00);
    r(A_COUNT_LO, v2);
    chk(v2 != 8'h00, 1'b1);
    w(A_TIMER_CTRL, 8'h30);
    w(A_WRAP_HI, 8'h00);
    w(A_WRAP_LO, 8'h03);
    w(A_TIMER_CTRL, 8'h40);
    for (int i = 0; i < 40 && ovf_irq !== 1'b1; i++) idle(1);
    chk(ovf_irq, 1'b1);
    r(A_TIMER_CTRL, v);
    idle(8);
    w(A_TIMER_CTRL, 8'h60);
    r(A_TIMER_CTRL, v);
    chk(v, 8'hE0);
    w(A_TIMER_CTRL, 8'h60);
    w(A_TIMER_CTRL, 8'hE0);
    r(A_TIMER_CTRL, v);
    chk(v, 8'h60);
    chk(ovf_irq, 1'b0);
    w(A_TIMER_CTRL, 8'h30);
    w(A_WRAP_HI, 8'h00);
    w(A_TIMER_CTRL, 8'h00);
    idle(20);
    r(A_TIMER_CTRL, v);
    chk(v, 8'h00);
    w(A_WRAP_LO, 8'h05);
    idle(14);
    r(A_TIMER_CTRL, v);
    chk(v, 8'h80);
    for (int el = 1; el < 4; el++) begin
      w(A_TIMER_CTRL, 8'h30);
      drive_lvl <= 2'h0;
      w(4'h5, {4'h4, el[1:0], 2'h0});
      drive_lvl <= 2'h1;
      idle(6);
      r(4'h5, v);
      chk(v[7], el[0]);
      chk(chan_irq[0], el[0]);
      w(4'h5, {4'h4, el[1:0], 2'h0});
      drive_lvl <= 2'h0;
      idle(6);
      r(4'h5, v);
      chk(v[7], el[1]);
      w(4'h5, {4'h4, el[1:0], 2'h0});
    end
    for (int el = 1; el < 4; el++) begin
      w(A_TIMER_CTRL, 8'h30);
      w(4'h5, {4'h1, el[1:0], 2'h0});
      w(4'h6, 8'h00);
      w(4'h7, 8'h02);
      w(A_TIMER_CTRL, 8'h00);
      idle(20);
      p1 = pin_out[0];
      idle(6);
      p2 = pin_out[0];
      chk(pin_oe[0], 1'b1);
      if (el == 1) chk(p1 ^ p2, 1'b1);
      else chk({p1, p2}, {2{el[0]}});
      r(4'h5, v);
      chk(v[7], 1'b1);
    end
    w(A_TIMER_CTRL, 8'h30);
    w(4'h5, 8'h1A);
    w(A_TIMER_CTRL, 8'h00);
    idle(12);
    highs(n);
    chk(n, 4'h3);
    w(4'h5, 8'h1B);
    idle(12);
    highs(n);
    chk(n, 4'h6);
    w(4'h6, 8'h00);
    w(4'h5, 8'h1A);
    idle(12);
    r(4'h5, v);
    chk(v[7], 1'b0);
    w(4'h7, 8'h02);
    idle(12);
    r(4'h5, v);
    chk(v[7], 1'b1);
    w(A_TIMER_CTRL, 8'h30);
    w(4'h5, 8'h10);
    w(4'h5, 8'h00);
    w(4'h8, 8'h1C);
    idle(3);
    chk(pin_oe[1], 1'b1);
    w(4'h5, 8'h2C);
    w(4'h8, 8'h44);
    idle(3);
    chk(pin_oe[1], 1'b0);
    w(4'h5, 8'h2A);
    w(A_TIMER_CTRL, 8'h00);
    idle(12);
    highs(n);
    chk(n, 4'h3);
    w(4'h9, 8'h00);
    w(4'hA, 8'h04);
    idle(12);
    highs(n);
    chk(n, 4'h5);
    reset_n <= 1'b0;
    idle(4);
    reset_n <= 1'b1;
    r(A_TIMER_CTRL, v);
    chk(v, 8'h20);
    r(4'h5, v);
    chk(v, 8'h00);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ===== verification/pin_partner.sv
// far-side model of the two shared channel pins
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  input wire logic [1:0] drive_lvl,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_lvl
);
  // the timer's drive wins; a port-owned pin shows the outside driver
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & drive_lvl);
endmodule
`default_nettype wire

// ===== verification/timer_chk.sv
// concurrent checks on the timer's bus, pins and requests
`timescale 1ns/1ns
`default_nettype none
module timer_chk
  import timer_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [timer_pkg::ADDR_W-1:0] addr,
  input wire logic [timer_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [timer_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] chan_pin_in,
  input wire logic [1:0] chan_pin_out,
  input wire logic [1:0] chan_pin_oe,
  input wire logic ovf_irq,
  input wire logic [1:0] chan_irq
);
  localparam logic [3:0] A_C0 = A_CHAN_BASE + CHAN_CTRL_OFS;
  logic ie_r, ie_q_r, cie_r, cie_q_r, fresh_r, frozen_r, latched_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // shadows of the enables, untouched wrap and a counter parked at zero
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ie_r <= 1'b0;
      ie_q_r <= 1'b0;
      cie_r <= 1'b0;
      cie_q_r <= 1'b0;
      fresh_r <= 1'b1;
      frozen_r <= 1'b1;
      latched_r <= 1'b0;
    end else begin
      ie_q_r <= ie_r;
      cie_q_r <= cie_r;
      if (wr && addr == A_TIMER_CTRL) begin
        ie_r <= wdata[B_OVF_IE];
        frozen_r <= wdata[B_HALT] && (frozen_r || (wdata[B_CLEAR] && !latched_r));
      end
      if (wr && addr == A_C0) cie_r <= wdata[B_CIE];
      if (wr && addr == A_WRAP_HI) fresh_r <= 1'b0;
      if (rd && addr == A_COUNT_HI) latched_r <= 1'b1;
      if (rd && addr == A_COUNT_LO) latched_r <= 1'b0;
    end
  end
  // channel 0 control write followed by a cycle without another
  sequence s_c0_write(logic cond);
    wr && addr == A_C0 && cond ##1 !(wr && addr == A_C0);
  endsequence
  a_clear_reads_zero: assert property (
    rd && addr == A_TIMER_CTRL |=> rdata[B_CLEAR] == 1'b0 && rdata[3] == 1'b0)
    else $error("clear bit or reserved bit read as one");
  a_ovf_irq_gated: assert property (ovf_irq |-> ie_r || ie_q_r)
    else $error("overflow request while its enable is off");
  a_chan_irq_gated: assert property (chan_irq[0] |-> cie_r || cie_q_r)
    else $error("channel request while its enable is off");
  a_preset_port_owned: assert property (
    s_c0_write(wdata[3:2] == EL_NONE) |-> ##1
      (!chan_pin_oe[0] && chan_pin_out[0] == !$past(wdata[B_UNBUF], 2)))
    else $error("preset pin driven or wrong preset level");
  a_capture_undriven: assert property (
    s_c0_write(!wdata[B_UNBUF] && !wdata[B_BUF] && wdata[3:2] != EL_NONE)
      |-> ##1 !chan_pin_oe[0])
    else $error("capture pin driven by the timer");
  a_buffered_frees_pin: assert property (
    s_c0_write(wdata[B_BUF]) |-> ##1 !chan_pin_oe[1])
    else $error("channel 1 pin still driven in buffered mode");
  a_halt_clear_zero: assert property (
    rd && addr == A_COUNT_LO && frozen_r |=> rdata == 8'h00)
    else $error("stopped counter not at zero");
  a_wrap_reset_ones: assert property (
    rd && addr == A_WRAP_HI && fresh_r |=> rdata == WRAP_RST[15:8])
    else $error("wrap high byte not all ones after reset");
endmodule
bind capture_compare_timer_regs timer_chk chk (.clock(clock), .reset_n(reset_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
  .ovf_irq(ovf_irq), .chan_irq(chan_irq));
`default_nettype wire
